// File: src/scl_timing.sv
// Purpose: SCL high and low count registers with a serial clock generator and idle detect.
// Assumes: Classic Wishbone on mclk; the serial clock logic runs on lclk.
// Notes:   Counts cross to lclk only while frozen, so no word changes under the capture.
// How it works
// - Count writes take effect only while disabled.
// - High counts below six are stored as six.
// - Low counts below eight are stored as eight.
// - Idle flagged when counter reaches standard high+10.
// - Standard speed high phase lasts standard high count.
// - Standard speed low phase lasts standard low count.
// - Fast speed high phase lasts fast high count.
// - Fast speed low phase lasts fast low count.
// - High speed uses the fast counts.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
`include "scl_timing_map.svh"

module scl_timing
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    input  wire logic [31:0]           wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_cyc_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  lclk,
    input  wire logic                  scl_i,
    output logic                       scl_o,
    output logic                       scl_oe,
    output logic                       bus_idle
);
    import scl_timing_pkg::*;

    logic        ack_q;
    logic [31:0] dat_q;
    logic        enable_q;
    logic        run_q;
    speed_t      speed_q;
    logic [15:0] std_high_q;
    logic [15:0] std_low_q;
    logic [15:0] fast_high_q;
    logic [15:0] fast_low_q;
    logic [2:0]  stat_s1_q;
    logic [2:0]  stat_s2_q;
    logic        req;
    logic        wr;
    logic        cnt_wr_ok;

    logic        rst_l1_q;
    logic        rst_l2_q;
    logic [3:0]  in_s1_q;
    logic [3:0]  in_s2_q;
    logic        ce_l;
    logic        en_l;
    logic        run_l;
    logic        scl_l;
    logic        en_l_d_q;
    logic        cap;
    logic        sel_fast;
    logic [15:0] hi_l_q;
    logic [15:0] lo_l_q;
    logic [15:0] idle_lim_l_q;
    logic [15:0] idle_cnt_q;
    logic        idle_l_q;
    logic [15:0] phase_cnt_q;
    gen_state_t  gen_q;
    logic        scl_oe_q;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        logic [15:0] v;
        v = old_v;
        if (sel[0])
        begin
            v[7:0] = dat[7:0];
        end
        if (sel[1])
        begin
            v[15:8] = dat[15:8];
        end
        return v;
    endfunction

    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                            input logic [15:0] lim);
        return (v < lim) ? lim : v;
    endfunction

    assign req       = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr        = req & wb_we_i;
    assign cnt_wr_ok = wr & ~enable_q;

    // Bus answer: one cycle after the request, for one cycle.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
        end
        else if (clk_en)
        begin
            ack_q <= req;
        end
    end

    // Unmapped addresses are acknowledged and read as zero.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            dat_q <= 32'h00000000;
        end
        else if (clk_en && req)
        begin
            unique case (wb_adr_i)
                `ADR_CTRL:      dat_q <= {28'h0000000, run_q, speed_q, enable_q};
                `ADR_STATUS:    dat_q <= {29'h00000000, stat_s2_q};
                `ADR_STD_HIGH:  dat_q <= {16'h0000, std_high_q};
                `ADR_STD_LOW:   dat_q <= {16'h0000, std_low_q};
                `ADR_FAST_HIGH: dat_q <= {16'h0000, fast_high_q};
                `ADR_FAST_LOW:  dat_q <= {16'h0000, fast_low_q};
                default:        dat_q <= 32'h00000000;
            endcase
        end
    end

    // The enable and run bits are always writable; only speed follows the same lock as the counts.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            enable_q <= 1'b0;
            run_q    <= 1'b0;
            speed_q  <= speed_t'(`RST_SPEED);
        end
        else if (clk_en && wr && wb_adr_i == `ADR_CTRL && wb_sel_i[0])
        begin
            enable_q <= wb_dat_i[`CTRL_ENABLE];
            run_q    <= wb_dat_i[`CTRL_RUN];
            if (!enable_q)
            begin
                speed_q <= speed_t'(wb_dat_i[`CTRL_SPEED_MSB:`CTRL_SPEED_LSB]);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            std_high_q  <= `RST_STD_HIGH;
            std_low_q   <= `RST_STD_LOW;
            fast_high_q <= `RST_FAST_HIGH;
            fast_low_q  <= `RST_FAST_LOW;
        end
        else if (clk_en && cnt_wr_ok)
        begin
            if (wb_adr_i == `ADR_STD_HIGH)
            begin
                std_high_q <= clamp16(merge16(std_high_q, wb_dat_i, wb_sel_i), `MIN_HIGH);
            end
            if (wb_adr_i == `ADR_STD_LOW)
            begin
                std_low_q <= clamp16(merge16(std_low_q, wb_dat_i, wb_sel_i), `MIN_LOW);
            end
            if (wb_adr_i == `ADR_FAST_HIGH)
            begin
                fast_high_q <= clamp16(merge16(fast_high_q, wb_dat_i, wb_sel_i), `MIN_HIGH);
            end
            if (wb_adr_i == `ADR_FAST_LOW)
            begin
                fast_low_q <= clamp16(merge16(fast_low_q, wb_dat_i, wb_sel_i), `MIN_LOW);
            end
        end
    end

    // Status levels from the link domain pass two flip-flops each.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            stat_s1_q <= 3'h0;
            stat_s2_q <= 3'h0;
        end
        else if (clk_en)
        begin
            stat_s1_q <= {scl_oe_q, scl_l, idle_l_q};
            stat_s2_q <= stat_s1_q;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign bus_idle = stat_s2_q[`STAT_IDLE];

    // Link-domain reset asserts at once and releases on lclk, so no state leaves reset unevenly.
    always_ff @(posedge lclk or posedge rst)
    begin
        if (rst)
        begin
            rst_l1_q <= 1'b1;
            rst_l2_q <= 1'b1;
        end
        else
        begin
            rst_l1_q <= 1'b0;
            rst_l2_q <= rst_l1_q;
        end
    end

    // The synchronisers keep running while frozen so that the freeze itself is seen.
    always_ff @(posedge lclk or posedge rst_l2_q)
    begin
        if (rst_l2_q)
        begin
            in_s1_q <= 4'h0;
            in_s2_q <= 4'h0;
        end
        else
        begin
            in_s1_q <= {scl_i, run_q, enable_q, clk_en};
            in_s2_q <= in_s1_q;
        end
    end

    assign ce_l     = in_s2_q[0];
    assign en_l     = in_s2_q[1];
    assign run_l    = in_s2_q[2];
    assign scl_l    = in_s2_q[3];
    assign cap      = en_l & ~en_l_d_q;
    assign sel_fast = (speed_q == SPEED_FAST) || (speed_q == SPEED_HIGH);

    // The count words are captured only after the enable arrives; they cannot change then.
    always_ff @(posedge lclk or posedge rst_l2_q)
    begin
        if (rst_l2_q)
        begin
            en_l_d_q     <= 1'b0;
            hi_l_q       <= `RST_STD_HIGH;
            lo_l_q       <= `RST_STD_LOW;
            idle_lim_l_q <= `RST_STD_HIGH + `IDLE_MARGIN;
        end
        else if (ce_l)
        begin
            en_l_d_q <= en_l;
            if (cap)
            begin
                hi_l_q       <= sel_fast ? fast_high_q : std_high_q;
                lo_l_q       <= sel_fast ? fast_low_q : std_low_q;
                idle_lim_l_q <= std_high_q + `IDLE_MARGIN;
            end
        end
    end

    // The idle counter runs while SCL is high and stops at its threshold.
    always_ff @(posedge lclk or posedge rst_l2_q)
    begin
        if (rst_l2_q)
        begin
            idle_cnt_q <= 16'h0000;
            idle_l_q   <= 1'b0;
        end
        else if (ce_l)
        begin
            if (!en_l_d_q || !scl_l)
            begin
                idle_cnt_q <= 16'h0000;
                idle_l_q   <= 1'b0;
            end
            else if (idle_cnt_q == idle_lim_l_q)
            begin
                idle_l_q <= 1'b1;
            end
            else
            begin
                idle_cnt_q <= idle_cnt_q + 16'h0001;
            end
        end
    end

    // The high phase only counts while SCL is seen high, so a slave that stretches is honoured.
    always_ff @(posedge lclk or posedge rst_l2_q)
    begin
        if (rst_l2_q)
        begin
            gen_q       <= GEN_IDLE;
            phase_cnt_q <= 16'h0000;
            scl_oe_q    <= 1'b0;
        end
        else if (ce_l)
        begin
            unique case (gen_q)
                GEN_IDLE:
                begin
                    if (en_l_d_q && run_l && idle_l_q)
                    begin
                        gen_q       <= GEN_LOW;
                        phase_cnt_q <= 16'h0001;
                        scl_oe_q    <= 1'b1;
                    end
                end
                GEN_LOW:
                begin
                    if (!en_l)
                    begin
                        gen_q    <= GEN_IDLE;
                        scl_oe_q <= 1'b0;
                    end
                    else if (phase_cnt_q >= lo_l_q)
                    begin
                        gen_q       <= GEN_HIGH;
                        phase_cnt_q <= 16'h0000;
                        scl_oe_q    <= 1'b0;
                    end
                    else
                    begin
                        phase_cnt_q <= phase_cnt_q + 16'h0001;
                    end
                end
                GEN_HIGH:
                begin
                    if (!en_l)
                    begin
                        gen_q <= GEN_IDLE;
                    end
                    else if (scl_l && phase_cnt_q >= hi_l_q - 16'h0001)
                    begin
                        gen_q       <= run_l ? GEN_LOW : GEN_IDLE;
                        phase_cnt_q <= 16'h0001;
                        scl_oe_q    <= run_l;
                    end
                    else if (scl_l)
                    begin
                        phase_cnt_q <= phase_cnt_q + 16'h0001;
                    end
                end
                default:
                begin
                    gen_q    <= GEN_IDLE;
                    scl_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // The pin is open drain: only the enable moves, the driven level is always low.
    always_ff @(posedge lclk or posedge rst_l2_q)
    begin
        if (rst_l2_q)
        begin
            scl_o <= 1'b0;
        end
        else
        begin
            scl_o <= 1'b0;
        end
    end

    assign scl_oe = scl_oe_q;

    AST_WRITE_LOCKED: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && wr && enable_q && wb_adr_i == `ADR_STD_LOW) |=> $stable(std_low_q))
        else $error("count register changed while enabled");

    AST_HIGH_CLAMP: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && cnt_wr_ok && wb_adr_i == `ADR_FAST_HIGH && wb_sel_i == 4'hf
            && wb_dat_i[15:0] < `MIN_HIGH) |=> fast_high_q == `MIN_HIGH)
        else $error("fast high count not clamped to six");

    AST_LOW_CLAMP: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && cnt_wr_ok && wb_adr_i == `ADR_STD_LOW && wb_sel_i == 4'hf
            && wb_dat_i[15:0] < `MIN_LOW) |=> std_low_q == `MIN_LOW)
        else $error("standard low count not clamped to eight");

    AST_IDLE_FLAG: assert property (@(posedge lclk) disable iff (rst_l2_q)
        (ce_l && en_l_d_q && scl_l && idle_cnt_q == idle_lim_l_q) |=> idle_l_q)
        else $error("idle not flagged at threshold");

    AST_IDLE_LIMIT: assert property (@(posedge lclk) disable iff (rst_l2_q)
        (ce_l && cap) |=> idle_lim_l_q == std_high_q + `IDLE_MARGIN)
        else $error("idle threshold not standard high plus ten");

    AST_LOW_PHASE: assert property (@(posedge lclk) disable iff (rst_l2_q)
        ($fell(scl_oe_q) && $past(gen_q) == GEN_LOW && gen_q == GEN_HIGH)
            |-> $past(phase_cnt_q) == lo_l_q)
        else $error("low phase length differs from low count");

    AST_HIGH_PHASE: assert property (@(posedge lclk) disable iff (rst_l2_q)
        ($rose(scl_oe_q) && $past(gen_q) == GEN_HIGH)
            |-> $past(phase_cnt_q) == hi_l_q - 16'h0001 && $past(scl_l))
        else $error("high phase length differs from high count");

    AST_FAST_SELECT: assert property (@(posedge lclk) disable iff (rst_l2_q)
        (ce_l && cap && sel_fast) |=> hi_l_q == fast_high_q && lo_l_q == fast_low_q)
        else $error("fast or high speed not using fast counts");

    AST_STD_SELECT: assert property (@(posedge lclk) disable iff (rst_l2_q)
        (ce_l && cap && !sel_fast) |=> hi_l_q == std_high_q && lo_l_q == std_low_q)
        else $error("standard speed not using standard counts");

    AST_ACK_ONE: assert property (@(posedge mclk) disable iff (rst)
        ack_q |=> !ack_q)
        else $error("ack longer than one cycle");

endmodule // scl_timing

// File: src/scl_timing_map.svh
// Purpose: Addresses, field positions, reset values and limits of the SCL timing block.
// Assumes: Included by its bare name from the design file.
// Notes:   Definitions only.
`ifndef SCL_TIMING_MAP_SVH
`define SCL_TIMING_MAP_SVH

`define ADR_CTRL         32'h50001400
`define ADR_STATUS       32'h50001404
`define ADR_STD_HIGH     32'h50001414
`define ADR_STD_LOW      32'h50001418
`define ADR_FAST_HIGH    32'h5000141c
`define ADR_FAST_LOW     32'h50001420

`define RST_STD_HIGH     16'h0048
`define RST_STD_LOW      16'h004f
`define RST_FAST_HIGH    16'h0008
`define RST_FAST_LOW     16'h0017
`define RST_SPEED        2'h1

`define MIN_HIGH         16'h0006
`define MIN_LOW          16'h0008
`define IDLE_MARGIN      16'h000a

`define CTRL_ENABLE      0
`define CTRL_SPEED_LSB   1
`define CTRL_SPEED_MSB   2
`define CTRL_RUN         3

`define STAT_IDLE        0
`define STAT_SCL         1
`define STAT_ACTIVE      2

`endif

// File: src/scl_timing_pkg.sv
// Purpose: Types shared by the SCL timing block.
// Assumes: Nothing.
// Notes:   Speed code 2'b00 is treated as standard speed.
package scl_timing_pkg;

    typedef enum logic [1:0] {
        SPEED_RSVD = 2'b00,
        SPEED_STD  = 2'b01,
        SPEED_FAST = 2'b10,
        SPEED_HIGH = 2'b11
    } speed_t;

    typedef enum logic [1:0] {
        GEN_IDLE = 2'b00,
        GEN_LOW  = 2'b01,
        GEN_HIGH = 2'b10
    } gen_state_t;

endpackage

// File: tb/scl_bus_partner.sv
// Purpose: Open-drain SCL wire with pull-up and a slave that may stretch the clock.
// Assumes: scl_oe high means the master pulls SCL low.
// Notes:   A stretch keeps SCL low for that many lclk cycles after the master lets go.
`timescale 1ns/100ps
module scl_bus_partner
(
    input  wire logic       lclk,
    input  wire logic       rst,
    input  wire logic       scl_oe,
    input  wire logic [3:0] stretch,
    output logic            scl
);
    logic [3:0] hold_q;

    // Reloaded while the master drives, so SCL never glitches high between the two pull-downs.
    always_ff @(posedge lclk or posedge rst)
    begin
        if (rst)
            hold_q <= 4'h0;
        else if (scl_oe)
            hold_q <= stretch;
        else if (hold_q != 4'h0)
            hold_q <= hold_q - 4'h1;
    end

    assign scl = !(scl_oe || hold_q != 4'h0);
endmodule // scl_bus_partner

// File: tb/scl_timing_test.sv
// Purpose: Self-checking bench for the SCL count registers and clock generator.
// Assumes: Classic Wishbone on mclk, link clock lclk of 32 ns.
// Notes:   Phase lengths are counted in lclk samples of scl_oe.
`timescale 1ns/100ps
`include "scl_timing_map.svh"
module scl_timing_test;
    logic        mclk, rst, lclk, scl, we, stb, ack, scl_oe, scl_o, bus_idle;
    logic        meas_en, oe_prev, armed;
    logic [31:0] adr, wdat, rdat, rng;
    logic [3:0]  sel, stretch;
    logic [15:0] run;
    logic [31:0] exp_rd_q[$];
    logic [15:0] exp_lo_q[$];
    logic [15:0] exp_hi_q[$];
    int          n_errors;
    int          cmp_count;

    scl_timing u_scl_timing (.mclk(mclk), .rst(rst), .clk_en(1'b1), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb), .wb_cyc_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .lclk(lclk), .scl_i(scl), .scl_o(scl_o),
        .scl_oe(scl_oe), .bus_idle(bus_idle));
    scl_bus_partner u_scl_bus_partner (.lclk(lclk), .rst(rst), .scl_oe(scl_oe),
        .stretch(stretch), .scl(scl));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial
    begin
        lclk = 1'b0;
        #3;
        forever #16 lclk = ~lclk;
    end

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic [31:0] a, input logic [31:0] d, input logic w);
        // Callers may arrive on an lclk edge; the request must start on an mclk edge.
        @(posedge mclk);
        adr  <= a;
        wdat <= d;
        we   <= w;
        sel  <= 4'hf;
        stb  <= 1'b1;
        @(posedge mclk);
        while (ack !== 1'b1)
            @(posedge mclk);
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_rd_q.push_back(e);
        wb(a, 32'h0, 1'b0);
    endtask

    // Read data is judged at the very edge where the master samples ack.
    always @(posedge mclk)
        if (ack === 1'b1 && we === 1'b0 && exp_rd_q.size() > 0)
            cmp32(rdat, exp_rd_q.pop_front());

    // High runs carry the scl_i sync lag, so only a window of four is allowed there.
    always @(posedge lclk)
    begin
        if (scl_oe !== oe_prev)
        begin
            if (armed && oe_prev && exp_lo_q.size() > 0)
                cmp16(run, exp_lo_q.pop_front());
            if (armed && !oe_prev && exp_hi_q.size() > 0)
                cmp16((run - exp_hi_q.pop_front()) >> 2, 16'h0);
            armed = meas_en;
            run   = 16'h0;
        end
        oe_prev = scl_oe;
        run++;
    end

    task automatic phases(input logic [1:0] spd, input logic [3:0] st);
        logic [15:0] sh, sl, fh, fl;
        int          n;
        sh = 16'h6 + 16'(rnd() % 12);
        sl = 16'h8 + 16'(rnd() % 12);
        fh = 16'h6 + 16'(rnd() % 12);
        fl = 16'h8 + 16'(rnd() % 12);
        wb(`ADR_STD_HIGH, {16'h0, sh}, 1'b1);
        wb(`ADR_STD_LOW, {16'h0, sl}, 1'b1);
        wb(`ADR_FAST_HIGH, {16'h0, fh}, 1'b1);
        wb(`ADR_FAST_LOW, {16'h0, fl}, 1'b1);
        repeat (3)
        begin
            exp_lo_q.push_back(spd[1] ? fl : sl);
            exp_hi_q.push_back((spd[1] ? fh : sh) + 16'(st) + 16'h2);
        end
        stretch <= st;
        meas_en = 1'b1;
        wb(`ADR_CTRL, {28'h0, 1'b1, spd, 1'b1}, 1'b1);
        n = 0;
        while (scl_oe !== 1'b1 && n < 500)
        begin
            @(posedge lclk);
            n++;
        end
        cmp16((16'(n) - sh - 16'ha) >> 3, 16'h0);
        // The idle flag stands until SCL is seen low, two lclk cycles after the first pull.
        cmp16({14'h0, scl_o, bus_idle}, 16'h0001);
        wb(`ADR_STD_LOW, 32'hffff, 1'b1);
        rd(`ADR_STD_LOW, {16'h0, sl});
        wb(`ADR_CTRL, {28'h0, 1'b1, ~spd, 1'b1}, 1'b1);
        rd(`ADR_CTRL, {28'h0, 1'b1, spd, 1'b1});
        n = 0;
        while ((exp_lo_q.size() + exp_hi_q.size()) > 0 && n < 2000)
        begin
            @(posedge lclk);
            n++;
        end
        cmp16(16'(exp_lo_q.size() + exp_hi_q.size()), 16'h0);
        meas_en = 1'b0;
        wb(`ADR_CTRL, {29'h0, spd, 1'b0}, 1'b1);
        $display("test phases speed %0d stretch %0d done", spd, st);
    endtask

    task automatic finish_test();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_errors++;
        finish_test();
    end

    initial
    begin
        logic [15:0] v, m;
        logic [31:0] a;
        rng = 32'h00000035;
        rst = 1'b1;
        stb = 1'b0;
        we = 1'b0;
        adr = 32'h0;
        wdat = 32'h0;
        sel = 4'h0;
        stretch = 4'h0;
        meas_en = 1'b0;
        oe_prev = 1'b0;
        armed = 1'b0;
        run = 16'h0;
        n_errors = 0;
        cmp_count = 0;
        repeat (5) @(posedge mclk);
        // The lclk side needs three of its own edges inside reset as well.
        repeat (3) @(posedge lclk);
        @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge lclk);
        @(posedge mclk);
        cmp16({15'h0, bus_idle}, 16'h0);
        rd(`ADR_STD_HIGH, {16'h0, `RST_STD_HIGH});
        rd(`ADR_STD_LOW, {16'h0, `RST_STD_LOW});
        rd(`ADR_FAST_HIGH, {16'h0, `RST_FAST_HIGH});
        rd(`ADR_FAST_LOW, {16'h0, `RST_FAST_LOW});
        wb(32'h50001424, 32'hffffffff, 1'b1);
        rd(32'h50001424, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 16; i++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                a = `ADR_STD_HIGH + 32'(4 * k);
                m = (k % 2 == 1) ? `MIN_LOW : `MIN_HIGH;
                v = (i < 9) ? 16'(i) : 16'(rnd());
                wb(a, {16'hffff, v}, 1'b1);
                rd(a, {16'h0, (v < m) ? m : v});
            end
        end
        $display("test clamp done");
        phases(2'b01, 4'h0);
        phases(2'b10, 4'h0);
        phases(2'b11, 4'h0);
        phases(2'b00, 4'h4);
        finish_test();
    end
endmodule // scl_timing_test
